// file: logic/imv_edge.sv
// module: rising edge detector for the gpio interrupt conditions
`timescale 1ns/1ps
module imv_edge #(
	parameter int N = 3
) (
	input  wire logic         sys_clk_i,
	input  wire logic         reset_i,
	input  wire logic [N-1:0] cond_i,
	output logic      [N-1:0] edge_o
);

	logic [N-1:0] prev_r;

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_bit
			always_ff @(posedge sys_clk_i or posedge reset_i) begin
				if (reset_i) begin
					prev_r[g] <= 1'b0;
				end else begin
					prev_r[g] <= cond_i[g];
				end
			end
			// RULE13 edge not level
			assign edge_o[g] = cond_i[g] & ~prev_r[g];
		end
	endgenerate

endmodule

// file: logic/imv_pkg.sv
// package: register map, field layout and vector table of the interrupt mask block
package imv_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int SRC_W  = 24;

	////////////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [7:0] OFS_POST_CLR_A  = 8'hDA;
	localparam logic [7:0] OFS_POST_CLR_B  = 8'hDB;
	localparam logic [7:0] OFS_POST_CLR_C  = 8'hDC;
	localparam logic [7:0] OFS_SOFT_CTRL   = 8'hDE;
	localparam logic [7:0] OFS_MASK_C      = 8'hDF;
	localparam logic [7:0] OFS_MASK_A      = 8'hE0;
	localparam logic [7:0] OFS_MASK_B      = 8'hE1;
	localparam logic [7:0] OFS_VECTOR      = 8'hE2;
	localparam logic [7:0] OFS_EVT_STATUS  = 8'hE3;
	localparam logic [7:0] OFS_EVT_CLEAR   = 8'hE4;
	localparam logic [7:0] OFS_EVT_ENABLE  = 8'hE5;

	////////////////////////////////////////////////////////////////////////////////
	// field layout: group a in bits 7:0, group b in 15:8, group c in 23:16
	localparam logic [7:0]  IMPL_A          = 8'hFD;
	localparam logic [7:0]  IMPL_B          = 8'h60;
	localparam logic [7:0]  IMPL_C          = 8'h16;
	localparam logic [7:0]  MASK_A_RW       = 8'hFF;
	localparam int          SOFT_EN_BIT     = 7;
	localparam int          SRC_GPIO0       = 4;
	localparam int          SRC_GPIO1       = 7;
	localparam int          SRC_GPIO2       = 20;
	localparam int          EVT_W           = 3;
	localparam int          EVT_SOFT_POST   = 0;
	localparam int          EVT_CLEAR_ALL   = 1;
	localparam int          EVT_TAKEN       = 2;

	////////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0]  RST_MASK        = 8'h00;
	localparam logic        RST_SOFT_EN     = 1'b0;
	localparam logic [SRC_W-1:0] RST_POSTED = 24'h000000;
	localparam logic [7:0]  NO_VECTOR       = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// vector table index per source bit; lower index wins, 8'hFF marks a reserved bit
	localparam logic [7:0] VEC_IDX [SRC_W] = '{
		8'h01, 8'hFF, 8'h0B, 8'h0C, 8'h09, 8'h07, 8'h19, 8'h0A,
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h05, 8'h0F, 8'hFF,
		8'hFF, 8'h11, 8'h12, 8'hFF, 8'h14, 8'hFF, 8'hFF, 8'hFF
	};

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} imv_bus_req_t;

endpackage

// file: logic/imv_top.sv
// module: interrupt masking, software posting and vector readout
//
// Contract
// RULE1 - masked source's posted flag never becomes pending.
// RULE2 - posting still happens while the mask bit is zero.
// RULE3 - each mask bit gates only its own source.
// RULE4 - mask bit one lets the posted flag become pending.
// RULE5 - soft enable zero: written ones to post/clear registers ignored.
// RULE6 - soft enable zero: written zeros clear posted flags.
// RULE7 - soft enable one: written zeros to post/clear registers ignored.
// RULE8 - soft enable one: written ones post the flags.
// RULE9 - soft enable sits in bit 7 of control register, reset zero.
// RULE10 - mask group c: gpio port 2 bit4, ext input 2 bit2, wrap bit1.
// RULE11 - mask group b: interval timer bit6, 1 ms timer bit5.
// RULE12 - mask group a: seven sources, bit 1 reserved. The mask a register still writes and reads back bit 1.
// RULE13 - gpio interrupts post on a detected edge.
// RULE14 - vector read returns highest priority pending vector.
// RULE15 - any vector register write clears all pending interrupts.
// RULE16 - posted flag holds until taken or cleared by software.
// RULE17 - post/clear read shows a one per posted source.
// RULE18 - hardware set beats a same-cycle clear.
// RULE19 - taking an interrupt clears its flag as the vector goes out.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module imv_top (
	input  wire logic                            sys_clk_i,
	input  wire logic                            reset_i,
	input  wire imv_pkg::imv_bus_req_t           bus_req_i,
	output logic [imv_pkg::DATA_W-1:0]           rdata_o,
	input  wire logic [imv_pkg::SRC_W-1:0]       src_event_i,
	input  wire logic [2:0]                      gpio_cond_i,
	input  wire logic                            irq_ack_i,
	output logic                                 irq_req_o,
	output logic [imv_pkg::DATA_W-1:0]           ack_vector_o,
	output logic                                 irq_o
);

	localparam logic [imv_pkg::SRC_W-1:0] IMPL = {imv_pkg::IMPL_C, imv_pkg::IMPL_B, imv_pkg::IMPL_A};

	logic [imv_pkg::SRC_W-1:0]  posted_r;
	logic [imv_pkg::SRC_W-1:0]  posted_nxt;
	logic [7:0]                 mask_a_r;
	logic [7:0]                 mask_b_r;
	logic [7:0]                 mask_c_r;
	logic                       soft_en_r;
	logic [imv_pkg::SRC_W-1:0]  mask_all;
	logic [imv_pkg::SRC_W-1:0]  pending;
	logic [imv_pkg::SRC_W-1:0]  hw_set;
	logic [imv_pkg::SRC_W-1:0]  top_onehot;
	logic [7:0]                 top_vector;
	logic [2:0]                 gpio_edge;
	logic [imv_pkg::EVT_W-1:0]  evt_status_r;
	logic [imv_pkg::EVT_W-1:0]  evt_enable_r;
	logic [imv_pkg::EVT_W-1:0]  evt_set;
	logic [imv_pkg::DATA_W-1:0] rdata_r;
	logic                       irq_req_r;
	logic [imv_pkg::DATA_W-1:0] ack_vector_r;
	logic                       irq_r;
	logic                       wr_post_a;
	logic                       wr_post_b;
	logic                       wr_post_c;
	logic                       wr_vec;

	////////////////////////////////////////////////////////////////////////////////
	// source conditions

	imv_edge #(
		.N(3)
	) u_edge (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.cond_i    (gpio_cond_i),
		.edge_o    (gpio_edge)
	);

	always_comb begin
		hw_set = src_event_i;
		// RULE13 gpio posts on edge
		hw_set[imv_pkg::SRC_GPIO0] = gpio_edge[0];
		hw_set[imv_pkg::SRC_GPIO1] = gpio_edge[1];
		hw_set[imv_pkg::SRC_GPIO2] = gpio_edge[2];
		hw_set = hw_set & IMPL;
	end

	////////////////////////////////////////////////////////////////////////////////
	// masking and priority

	// RULE3 per bit gating
	assign mask_all = {mask_c_r, mask_b_r, mask_a_r} & IMPL;
	// RULE1 RULE4 pending gate
	assign pending  = posted_r & mask_all;

	// fixed table scan; ties cannot occur since the index of every implemented source is unique
	always_comb begin
		logic [7:0] best;
		best       = 8'hFF;
		top_onehot = '0;
		// RULE14 highest priority pick
		for (int i = 0; i < imv_pkg::SRC_W; i++) begin
			if (pending[i] && (imv_pkg::VEC_IDX[i] < best)) begin
				best       = imv_pkg::VEC_IDX[i];
				top_onehot = '0;
				top_onehot[i] = 1'b1;
			end
		end
		top_vector = (|pending) ? {best[5:0], 2'b00} : imv_pkg::NO_VECTOR;
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus decode

	assign wr_post_a = bus_req_i.wr && (bus_req_i.addr == imv_pkg::OFS_POST_CLR_A);
	assign wr_post_b = bus_req_i.wr && (bus_req_i.addr == imv_pkg::OFS_POST_CLR_B);
	assign wr_post_c = bus_req_i.wr && (bus_req_i.addr == imv_pkg::OFS_POST_CLR_C);
	assign wr_vec    = bus_req_i.wr && (bus_req_i.addr == imv_pkg::OFS_VECTOR);

	////////////////////////////////////////////////////////////////////////////////
	// posted flags

	always_comb begin
		logic [imv_pkg::SRC_W-1:0] wsel;
		logic [imv_pkg::SRC_W-1:0] wval;
		wsel = {{8{wr_post_c}}, {8{wr_post_b}}, {8{wr_post_a}}} & IMPL;
		wval = {3{bus_req_i.wdata}};
		posted_nxt = posted_r;
		if (soft_en_r) begin
			// RULE8 ones post; RULE7 zeros ignored
			posted_nxt = posted_nxt | (wsel & wval);
		end else begin
			// RULE6 zeros clear; RULE5 ones ignored
			posted_nxt = posted_nxt & ~(wsel & ~wval);
		end
		// RULE15 clear all pending
		if (wr_vec) begin
			posted_nxt = posted_nxt & ~pending;
		end
		// RULE19 taken source cleared
		if (irq_ack_i) begin
			posted_nxt = posted_nxt & ~top_onehot;
		end
		// RULE2 RULE18 hardware set wins, even when masked
		posted_nxt = posted_nxt | hw_set;
	end

	// RULE16 flag held otherwise
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			posted_r <= imv_pkg::RST_POSTED;
		end else begin
			posted_r <= posted_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// mask and control registers

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			mask_a_r  <= imv_pkg::RST_MASK;
			mask_b_r  <= imv_pkg::RST_MASK;
			mask_c_r  <= imv_pkg::RST_MASK;
			soft_en_r <= imv_pkg::RST_SOFT_EN;
		end else if (bus_req_i.wr) begin
			case (bus_req_i.addr)
				// RULE12 group a layout
				imv_pkg::OFS_MASK_A: begin
					mask_a_r <= bus_req_i.wdata & imv_pkg::MASK_A_RW;
				end
				// RULE11 group b layout
				imv_pkg::OFS_MASK_B: begin
					mask_b_r <= bus_req_i.wdata & imv_pkg::IMPL_B;
				end
				// RULE10 group c layout
				imv_pkg::OFS_MASK_C: begin
					mask_c_r <= bus_req_i.wdata & imv_pkg::IMPL_C;
				end
				// RULE9 soft enable bit
				imv_pkg::OFS_SOFT_CTRL: begin
					soft_en_r <= bus_req_i.wdata[imv_pkg::SOFT_EN_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// block events and interrupt line

	assign evt_set[imv_pkg::EVT_SOFT_POST] = soft_en_r && |({{8{wr_post_c}}, {8{wr_post_b}}, {8{wr_post_a}}}
		& IMPL & {3{bus_req_i.wdata}});
	assign evt_set[imv_pkg::EVT_CLEAR_ALL] = wr_vec;
	assign evt_set[imv_pkg::EVT_TAKEN]     = irq_ack_i && (|pending);

	// set beats clear so no event is lost
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			evt_status_r <= '0;
		end else if (bus_req_i.wr && (bus_req_i.addr == imv_pkg::OFS_EVT_CLEAR)) begin
			evt_status_r <= (evt_status_r & ~bus_req_i.wdata[imv_pkg::EVT_W-1:0]) | evt_set;
		end else begin
			evt_status_r <= evt_status_r | evt_set;
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			evt_enable_r <= '0;
		end else if (bus_req_i.wr && (bus_req_i.addr == imv_pkg::OFS_EVT_ENABLE)) begin
			evt_enable_r <= bus_req_i.wdata[imv_pkg::EVT_W-1:0];
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |((evt_status_r | evt_set) & evt_enable_r);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// cpu side request and vector

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			irq_req_r    <= 1'b0;
			ack_vector_r <= imv_pkg::NO_VECTOR;
		end else begin
			// pending after this cycle's updates, so a taken source drops at once
			irq_req_r <= |(posted_nxt & mask_all);
			if (irq_ack_i) begin
				// RULE19 vector out with clear
				ack_vector_r <= top_vector;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read data

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_r <= '0;
		end else if (bus_req_i.rd) begin
			case (bus_req_i.addr)
				// RULE17 posted readback
				imv_pkg::OFS_POST_CLR_A: rdata_r <= posted_r[7:0];
				imv_pkg::OFS_POST_CLR_B: rdata_r <= posted_r[15:8];
				imv_pkg::OFS_POST_CLR_C: rdata_r <= posted_r[23:16];
				imv_pkg::OFS_SOFT_CTRL:  rdata_r <= {soft_en_r, 7'h00};
				imv_pkg::OFS_MASK_A:     rdata_r <= mask_a_r;
				imv_pkg::OFS_MASK_B:     rdata_r <= mask_b_r;
				imv_pkg::OFS_MASK_C:     rdata_r <= mask_c_r;
				// RULE14 vector readout
				imv_pkg::OFS_VECTOR:     rdata_r <= top_vector;
				imv_pkg::OFS_EVT_STATUS: rdata_r <= {5'h00, evt_status_r};
				imv_pkg::OFS_EVT_ENABLE: rdata_r <= {5'h00, evt_enable_r};
				default:                 rdata_r <= 8'h00;
			endcase
		end else begin
			rdata_r <= 8'h00;
		end
	end

	assign rdata_o      = rdata_r;
	assign irq_req_o    = irq_req_r;
	assign ack_vector_o = ack_vector_r;
	assign irq_o        = irq_r;

endmodule

// file: sim/imv_top_bench.sv
// bench: register level tests of the interrupt mask block
`timescale 1ns/1ps
module imv_top_bench;
	localparam logic [7:0] RA [9] = '{8'hDA, 8'hDB, 8'hDC, 8'hDE, 8'hDF, 8'hE0, 8'hE1, 8'hE2, 8'hD0};
	localparam logic [7:0] MA [4] = '{8'hDF, 8'hE0, 8'hE1, 8'hDE};
	localparam logic [7:0] ME [4] = '{imv_pkg::IMPL_C, imv_pkg::MASK_A_RW, imv_pkg::IMPL_B, 8'h80};
	logic                  clk;
	logic                  rst;
	imv_pkg::imv_bus_req_t req;
	logic [7:0]            rdata;
	logic [23:0]           src;
	logic [2:0]            gpio;
	logic                  ack;
	logic                  irq_req;
	logic [7:0]            ack_vec;
	logic                  irq;
	int                    err_total;
	int                    check_count;
	imv_top u_dut (.sys_clk_i(clk), .reset_i(rst), .bus_req_i(req), .rdata_o(rdata), .src_event_i(src),
		.gpio_cond_i(gpio), .irq_ack_i(ack), .irq_req_o(irq_req), .ack_vector_o(ack_vec), .irq_o(irq));
	always #25 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// hardware events ride along with the write so same-cycle races can be made
	task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [23:0] s);
		@(posedge clk);
		req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		src <= s;
		@(posedge clk);
		req.wr <= 1'b0;
		src <= 24'h000000;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	task automatic take(input logic [7:0] exp);
		@(posedge clk);
		ack <= 1'b1;
		@(posedge clk);
		ack <= 1'b0;
		#1 chk(ack_vec, exp);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3000) @(posedge clk);
		err_total++;
		report_and_stop();
	end
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		req = '0;
		src = 24'h000000;
		gpio = 3'h0;
		ack = 1'b0;
		err_total = 0;
		check_count = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		foreach (RA[i]) rdc(RA[i], 8'h00);
		foreach (MA[i]) wr(MA[i], 8'hFF, 24'h000000);
		foreach (MA[i]) rdc(MA[i], ME[i]);
		foreach (MA[i]) wr(MA[i], 8'h00, 24'h000000);
		$display("test registers done");
		wr(8'hD0, 8'h00, 24'h020001);
		rdc(8'hDA, 8'h01);
		chk(8'(irq_req), 8'h00);
		rdc(8'hDC, 8'h02);
		wr(8'hDF, 8'h02, 24'h000000);
		rdc(8'hE2, 8'h44);
		chk(8'(irq_req), 8'h01);
		wr(8'hE2, 8'h5A, 24'h000000);
		rdc(8'hDC, 8'h00);
		rdc(8'hE3, 8'h02);
		rdc(8'hDA, 8'h01);
		wr(8'hDA, 8'hFF, 24'h000000);
		rdc(8'hDA, 8'h01);
		wr(8'hDA, 8'hFE, 24'h000001);
		rdc(8'hDA, 8'h01);
		wr(8'hDA, 8'hFE, 24'h000000);
		rdc(8'hDA, 8'h00);
		$display("test posting done");
		gpio <= 3'h5;
		repeat (3) @(posedge clk);
		rdc(8'hDA, 8'h10);
		rdc(8'hDC, 8'h10);
		wr(8'hDA, 8'hEF, 24'h000000);
		wr(8'hDC, 8'hEF, 24'h000000);
		rdc(8'hDA, 8'h00);
		rdc(8'hDC, 8'h00);
		gpio <= 3'h0;
		$display("test gpio done");
		wr(8'hE4, 8'h07, 24'h000000);
		wr(8'hDE, 8'h80, 24'h000000);
		wr(8'hDB, 8'hFF, 24'h000000);
		rdc(8'hDB, imv_pkg::IMPL_B);
		wr(8'hDB, 8'h00, 24'h000000);
		rdc(8'hDB, imv_pkg::IMPL_B);
		rdc(8'hE3, 8'h01);
		chk(8'(irq), 8'h00);
		wr(8'hE5, 8'h01, 24'h000000);
		rdc(8'hE3, 8'h01);
		chk(8'(irq), 8'h01);
		wr(8'hE4, 8'h01, 24'h000000);
		rdc(8'hE3, 8'h00);
		chk(8'(irq), 8'h00);
		$display("test soft and event done");
		wr(8'hE1, 8'h60, 24'h000000);
		take(8'h14);
		rdc(8'hDB, 8'h40);
		take(8'h3C);
		rdc(8'hDB, 8'h00);
		chk(8'(irq_req), 8'h00);
		rdc(8'hE3, 8'h04);
		$display("test ack done");
		report_and_stop();
	end
endmodule

// file: sim/imv_top_sva.sv
// checker: port assertions of the interrupt mask block
`timescale 1ns/1ps
module imv_top_sva (
	input wire logic                  sys_clk_i,
	input wire logic                  reset_i,
	input wire imv_pkg::imv_bus_req_t bus_req_i,
	input wire logic [7:0]            rdata_o,
	input wire logic [23:0]           src_event_i,
	input wire logic [2:0]            gpio_cond_i,
	input wire logic                  irq_ack_i,
	input wire logic                  irq_req_o,
	input wire logic [7:0]            ack_vector_o,
	input wire logic                  irq_o
);
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);
	////////////////////////////////////////////////////////////////////////////////
	// access offsets, zero when idle; zero is never a mapped offset
	wire logic [7:0] ra = bus_req_i.rd ? bus_req_i.addr : 8'h00;
	wire logic [7:0] wa = bus_req_i.wr ? bus_req_i.addr : 8'h00;
	logic [2:0]      mz_r;
	logic            mzq_r;
	// all masks zero for two edges, so any lag of the request flop has passed
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			mz_r  <= 3'h7;
			mzq_r <= 1'b1;
		end else begin
			mzq_r <= &mz_r;
			if (wa == imv_pkg::OFS_MASK_A) mz_r[0] <= (bus_req_i.wdata & imv_pkg::IMPL_A) == 8'h00;
			if (wa == imv_pkg::OFS_MASK_B) mz_r[1] <= (bus_req_i.wdata & imv_pkg::IMPL_B) == 8'h00;
			if (wa == imv_pkg::OFS_MASK_C) mz_r[2] <= (bus_req_i.wdata & imv_pkg::IMPL_C) == 8'h00;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	chk_rdata_idle: assert property (!bus_req_i.rd |=> rdata_o == 8'h00)
		else $error("read data not zero after idle cycle");
	chk_ctrl_rsvd: assert property (ra == imv_pkg::OFS_SOFT_CTRL |=> rdata_o[6:0] == 7'h00)
		else $error("control reserved bits set");
	chk_mask_c_rsvd: assert property (ra == imv_pkg::OFS_MASK_C |=> (rdata_o & ~imv_pkg::IMPL_C) == 8'h00)
		else $error("mask c reserved bits set");
	chk_mask_b_rsvd: assert property (ra == imv_pkg::OFS_MASK_B |=> (rdata_o & ~imv_pkg::IMPL_B) == 8'h00)
		else $error("mask b reserved bits set");
	chk_post_a_rsvd: assert property (ra == imv_pkg::OFS_POST_CLR_A |=> !rdata_o[1])
		else $error("posted a reserved bit set");
	chk_vec_wipe: assert property (wa == imv_pkg::OFS_VECTOR && src_event_i == 24'h000000
		&& gpio_cond_i == 3'h0 && !irq_ack_i |=> !irq_req_o)
		else $error("request left after vector write");
	chk_ack_hold: assert property (!irq_ack_i |=> $stable(ack_vector_o))
		else $error("ack vector moved without ack");
	chk_masked_quiet: assert property (&mz_r && mzq_r |-> !irq_req_o)
		else $error("request while all masks zero");
endmodule
bind imv_top imv_top_sva u_sva (.sys_clk_i, .reset_i, .bus_req_i, .rdata_o, .src_event_i, .gpio_cond_i,
	.irq_ack_i, .irq_req_o, .ack_vector_o, .irq_o);
